// ==== bench/gp_pins_model.sv ====
// Purpose: peripherals and wiring on the sixteen port pins
// Assumes: outside drivers only on lines the bench keeps as input
// Notes:   undriven lines toggle every cycle, never a steady level
`timescale 1ns/1ps
`default_nettype none
module gp_pins_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] gp_out,
    input  wire logic [15:0] gp_oe,
    input  wire logic [15:0] ext_drv,
    input  wire logic [15:0] ext_val,
    output logic      [15:0] gp_in
);
    logic [15:0] float_lvl = 16'h5a3c;
    // a floating pad must not look like a stable answer
    always_ff @(posedge clk_sys) begin
        float_lvl <= ~float_lvl;
    end
    // port drives where enabled, peripherals only on input lines
    always_comb begin
        gp_in = (gp_oe & gp_out) | (~gp_oe & ext_drv & ext_val)
              | (~gp_oe & ~ext_drv & float_lvl);
    end
endmodule
`default_nettype wire

// ==== bench/gp_port_chk.sv ====
// Purpose: port-level assertions for the general purpose port
// Assumes: bound to every gp_port instance, one clock domain
// Notes:   sees only the top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "gp_port_cfg.svh"
module gp_port_chk (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire gp_port_pkg::bus_req_s bus_req,
    input  wire logic [`GP_DW-1:0]     rdata,
    input  wire logic [`GP_PINS-1:0]   gp_out,
    input  wire logic [`GP_PINS-1:0]   gp_oe,
    input  wire logic                  peri_irq,
    input  wire logic [`GP_HALF-1:0]   serial_alt_out,
    input  wire logic [`GP_HALF-1:0]   dma_alt_in,
    input  wire logic [`GP_HALF-1:0]   serial_alt_in,
    input  wire logic                  dma_mode,
    input  wire logic                  serial_mode,
    input  wire logic                  irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // short views of the request fields
    wire logic        w  = bus_req.wr;
    wire logic        r  = bus_req.rd;
    wire logic [7:0]  a  = bus_req.addr;
    wire logic [15:0] wd = bus_req.wdata[15:0];

    rdata_idle_a: assert property (!r |=> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    ctrl_read_a: assert property (
        r && a == `OFF_CTRL |=> rdata[1:0] == {$past(serial_mode), $past(dma_mode)})
        else $error("select bits read back differ from mode outputs");
    reset_idle_a: assert property (
        $rose(rst_n) |-> gp_oe == 16'h0 && gp_out == 16'h0)
        else $error("pins not idle after reset");
    oe_follow_a: assert property (
        (w && a == `OFF_DIR) ##1 !w |=> gp_oe == $past(wd, 2))
        else $error("drive enables do not follow the direction write");
    out_follow_a: assert property (
        (w && a == `OFF_LATCH && !dma_mode && !serial_mode) ##1 !w
        |=> gp_out == $past(wd, 2))
        else $error("plain outputs do not follow the latch write");
    alt_and_a: assert property (
        serial_mode && !(w && a == `OFF_CTRL)
        |=> ##1 (gp_out[15:8] & ~$past(serial_alt_out)) == 8'h00)
        else $error("upper pin high while alternate data low");
    ser_in_off_a: assert property (!serial_mode |-> serial_alt_in == 8'h00)
        else $error("serial alternate inputs live while unselected");
    dma_in_off_a: assert property (!dma_mode |-> dma_alt_in == 8'h00)
        else $error("dma alternate inputs live while unselected");
    upper_zero_a: assert property (
        r && (a == `OFF_DIR || a == `OFF_LATCH || a == `OFF_PIN) |=> rdata[31:16] == 16'h0)
        else $error("upper half of a port register read not zero");
    irq_clear_a: assert property (
        !peri_irq [*5] ##0 (w && a == `OFF_IRQ_STATUS && bus_req.wdata[1:0] == 2'h3)
        |=> ##1 !irq)
        else $error("interrupt stays high after status clear");
endmodule
bind gp_port gp_port_chk u_chk (.clk_sys, .rst_n, .bus_req, .rdata, .gp_out, .gp_oe,
    .peri_irq, .serial_alt_out, .dma_alt_in, .serial_alt_in, .dma_mode, .serial_mode, .irq);
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the general purpose port
// Assumes: gp_pins_model on the pins, bus task on the register port
// Notes:   expectations come from the bench copies of the registers
`timescale 1ns/1ps
`default_nettype none
`include "gp_port_cfg.svh"
module tb;
    logic                  clk_sys;
    logic                  rst_n          = 1'b0;
    gp_port_pkg::bus_req_s req            = '0;
    logic [31:0]           rdata;
    logic [15:0]           gp_in, gp_out, gp_oe;
    logic                  peri_irq       = 1'b0;
    gp_port_pkg::dma_ack_s dma_ack        = '0;
    logic [7:0]            dma_alt_out    = 8'h00;
    logic [7:0]            serial_alt_out = 8'h00;
    logic [7:0]            dma_alt_in, serial_alt_in;
    logic                  dma_mode, serial_mode, irq;
    logic [15:0]           ext_drv        = 16'hffff;
    logic [15:0]           ext_val        = 16'h0000;
    logic [3:0]            ctrl           = 4'h0;
    logic [15:0]           dir            = 16'h0000;
    logic [15:0]           lat            = 16'h0000;
    logic [15:0]           p, q;
    int                    errors         = 0;
    int                    compares       = 0;

    gp_port u_gp_port (.clk_sys, .rst_n, .bus_req(req), .rdata, .gp_in, .gp_out, .gp_oe,
        .peri_irq, .dma_ack, .dma_alt_out, .dma_alt_in, .serial_alt_out, .serial_alt_in,
        .dma_mode, .serial_mode, .irq);
    gp_pins_model u_gp_pins_model (.clk_sys, .gp_out, .gp_oe, .ext_drv, .ext_val, .gp_in);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one strobe cycle; returns where the read answer stands
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(n, e, rdata);
    endtask

    task automatic wait_irq(input logic e);
        int k;
        k = 0;
        while (irq !== e && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        check("irq", 32'(e), 32'(irq));
        if (irq !== e) report_and_stop();
    endtask

    task automatic pulse();
        @(posedge clk_sys);
        peri_irq <= 1'b1;
        idle(4);
        @(posedge clk_sys);
        peri_irq <= 1'b0;
        idle(6);
    endtask

    // expected pin outputs: alternate data gated by the latch
    function automatic logic [15:0] out_exp();
        logic [15:0] alt;
        logic [15:0] sel;
        alt = {serial_alt_out, dma_alt_out[7:4], dma_ack};
        sel = {{8{ctrl[1]}}, {8{ctrl[0]}}};
        if (ctrl[0] && ctrl[2]) begin
            alt[0] = dma_ack.tx_a | dma_ack.rx_a;
            alt[2] = dma_ack.tx_b | dma_ack.rx_b;
            sel[1] = 1'b0;
            sel[3] = 1'b0;
        end
        return (sel & alt & lat) | (~sel & lat);
    endfunction

    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hc019));
        ext_val <= 16'($urandom);
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        idle(4);
        // reset state, unmapped and read-only places
        check("gp_oe", 32'h0, 32'(gp_oe));
        check("gp_out", 32'h0, 32'(gp_out));
        rd(`OFF_CTRL, "ctrl", 32'h0);
        rd(`OFF_DIR, "dir", 32'h0);
        rd(`OFF_LATCH, "latch", 32'(ext_val));
        rd(`OFF_IRQ_MASK, "mask", 32'h0);
        bus(1'b1, 8'h24, 32'hffff);
        bus(1'b1, `OFF_PIN, 32'hffff);
        rd(8'h24, "unmapped", 32'h0);
        rd(`OFF_DIR, "dir", 32'h0);
        // plain lines with random directions and read-modify-writes
        for (int i = 0; i < 8; i++) begin
            lat = (i == 0) ? 16'hffff : 16'($urandom);
            bus(1'b1, `OFF_LATCH, 32'(lat));
            dir = (i == 1) ? 16'hffff : 16'($urandom);
            @(posedge clk_sys);
            ext_drv <= ~dir;
            ext_val <= 16'($urandom);
            bus(1'b1, `OFF_DIR, 32'(dir));
            idle(4);
            p = (dir & lat) | (~dir & ext_val);
            check("gp_oe", 32'(dir), 32'(gp_oe));
            check("gp_out", 32'(lat), 32'(gp_out));
            rd(`OFF_LATCH, "latch", 32'(p));
            rd(`OFF_PIN, "pin", 32'(p));
            q = 16'($urandom);
            bus(1'b1, `OFF_LATCH_SET, 32'(q));
            lat = p | q;
            idle(4);
            p = (dir & lat) | (~dir & ext_val);
            q = 16'($urandom);
            bus(1'b1, `OFF_LATCH_CLR, 32'(q));
            lat = p & ~q;
            idle(2);
            check("gp_out", 32'(lat), 32'(gp_out));
        end
        // every select and combine setting
        for (int m = 0; m < 8; m++) begin
            ctrl = 4'(m);
            lat = m[0] ? 16'hffff : 16'($urandom);
            bus(1'b1, `OFF_LATCH, 32'(lat));
            @(posedge clk_sys);
            dma_alt_out <= 8'($urandom);
            serial_alt_out <= 8'($urandom);
            dma_ack <= 4'($urandom);
            bus(1'b1, `OFF_CTRL, 32'(ctrl));
            idle(3);
            p = (dir & lat) | (~dir & ext_val);
            check("gp_out", 32'(out_exp()), 32'(gp_out));
            check("gp_oe", 32'(dir), 32'(gp_oe));
            check("serial_alt_in", ctrl[1] ? 32'(p[15:8]) : 32'h0, 32'(serial_alt_in));
            check("dma_alt_in", ctrl[0] ? 32'(p[7:0]) : 32'h0, 32'(dma_alt_in));
            rd(`OFF_CTRL, "ctrl", 32'(ctrl));
            rd(`OFF_LATCH, "latch", 32'(p));
        end
        // interrupt: dropped while disabled, vector per mode, overrun, mask
        bus(1'b1, `OFF_IRQ_MASK, 32'h1);
        bus(1'b1, `OFF_CTRL, 32'h0);
        pulse();
        rd(`OFF_IRQ_STATUS, "status", 32'h0);
        for (int m = 0; m < 4; m++) begin
            ctrl = 4'h8 | 4'(m);
            bus(1'b1, `OFF_CTRL, 32'(ctrl));
            pulse();
            wait_irq(1'b1);
            p = (dir & out_exp()) | (~dir & ext_val);
            q = {m[1] ? 8'h00 : p[15:8], m[0] ? 8'h00 : p[7:0]};
            rd(`OFF_VECTOR, "vector", {`VEC_TAG, q});
            bus(1'b1, `OFF_IRQ_STATUS, 32'h3);
            wait_irq(1'b0);
        end
        pulse();
        pulse();
        rd(`OFF_IRQ_STATUS, "status", 32'h3);
        bus(1'b1, `OFF_IRQ_MASK, 32'h0);
        wait_irq(1'b0);
        bus(1'b1, `OFF_IRQ_MASK, 32'h1);
        wait_irq(1'b1);
        bus(1'b1, `OFF_IRQ_STATUS, 32'h3);
        wait_irq(1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== src/gp_irq_unit.sv ====
// Purpose: sticky interrupt status, mask and level interrupt output
// Assumes: events are one-cycle pulses on clk_sys
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
`include "gp_port_cfg.svh"
module gp_irq_unit (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [`GP_IRQ_W-1:0] event_set,
    input  wire logic                 clr_wr,
    input  wire logic [`GP_IRQ_W-1:0] clr_data,
    input  wire logic                 mask_wr,
    input  wire logic [`GP_IRQ_W-1:0] mask_data,
    output logic      [`GP_IRQ_W-1:0] status,
    output logic      [`GP_IRQ_W-1:0] mask,
    output logic                      irq
);

    // write one to clear, new events always land
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status <= `RST_IRQ;
        end else if (clr_wr) begin
            status <= (status & ~clr_data) | event_set;
        end else begin
            status <= status | event_set;
        end
    end

    // mask bit high lets the status bit through
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask <= `RST_IRQ;
        end else if (mask_wr) begin
            mask <= mask_data;
        end
    end

    // level output, registered so it is glitch free
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

endmodule
`default_nettype wire

// ==== src/gp_port.sv ====
// Purpose: 16-line general purpose port with two switchable alternate halves
// Assumes: pins and the peripheral interrupt line are asynchronous to clk_sys
// Notes:   pad drivers sit outside; gp_oe high means this block drives the pin
`timescale 1ns/1ps
`default_nettype none
`include "gp_port_cfg.svh"
module gp_port (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // register port
    input  wire gp_port_pkg::bus_req_s      bus_req,
    output logic      [`GP_DW-1:0]          rdata,
    // pins
    input  wire logic [`GP_PINS-1:0]        gp_in,
    output logic      [`GP_PINS-1:0]        gp_out,
    output logic      [`GP_PINS-1:0]        gp_oe,
    // peripheral interrupt line on the port, active high
    input  wire logic                       peri_irq,
    // dma alternate function, lower half
    input  wire gp_port_pkg::dma_ack_s      dma_ack,
    input  wire logic [`GP_HALF-1:0]        dma_alt_out,
    output logic      [`GP_HALF-1:0]        dma_alt_in,
    // serial control alternate function, upper half
    input  wire logic [`GP_HALF-1:0]        serial_alt_out,
    output logic      [`GP_HALF-1:0]        serial_alt_in,
    // mode indications for the alternate function blocks
    output logic                            dma_mode,
    output logic                            serial_mode,
    // interrupt
    output logic                            irq
);

    gp_port_pkg::ctrl_s          ctrl;
    logic [`GP_PINS-1:0]         pin_direction_register;
    logic [`GP_PINS-1:0]         pin_output_latch_register;
    logic [`GP_PINS-1:0]         pin_level;
    logic                        peri_irq_s;
    logic                        peri_irq_q;
    logic [`GP_DW-1:0]           port_interrupt_vector;
    logic [`GP_PINS-1:0]         alt_sel;
    logic [`GP_PINS-1:0]         alt_data;
    logic [`GP_HALF-1:0]         dma_data;
    logic [`GP_PINS-1:0]         alt_in_all;
    logic [`GP_PINS-1:0]         readback;
    logic [`GP_PINS-1:0]         next_latch;
    logic                        latch_wr;
    logic                        vec_event;
    logic [`GP_IRQ_W-1:0]        irq_events;
    logic [`GP_IRQ_W-1:0]        irq_status;
    logic [`GP_IRQ_W-1:0]        irq_mask;
    logic [`GP_DW-1:0]           next_rdata;
    logic [`GP_HALF-1:0]         upper_byte_vector;
    logic [`GP_HALF-1:0]         lower_byte_vector;
    logic                        wr_ctrl;
    logic                        wr_dir;
    logic                        wr_latch;
    logic                        wr_set;
    logic                        wr_clr;
    logic                        wr_stat;
    logic                        wr_mask;

    // value a read returns: latch for outputs, sampled pin for inputs
    function automatic logic [`GP_PINS-1:0] line_value(
        input logic [`GP_PINS-1:0] dir,
        input logic [`GP_PINS-1:0] latch,
        input logic [`GP_PINS-1:0] pins
    );
        line_value = (dir & latch) | (~dir & pins);
    endfunction

    // pin levels and the interrupt line pass two flops; second stage is the input latch
    gp_sync #(
        .WIDTH (`GP_PINS + 1)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in ({peri_irq, gp_in}),
        .sync_out ({peri_irq_s, pin_level})
    );

    // write decode, one strobe per register
    always_comb begin
        wr_ctrl  = 1'b0;
        wr_dir   = 1'b0;
        wr_latch = 1'b0;
        wr_set   = 1'b0;
        wr_clr   = 1'b0;
        wr_stat  = 1'b0;
        wr_mask  = 1'b0;
        if (bus_req.wr) begin
            if (bus_req.addr == `OFF_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (bus_req.addr == `OFF_DIR) begin
                wr_dir = 1'b1;
            end else if (bus_req.addr == `OFF_LATCH) begin
                wr_latch = 1'b1;
            end else if (bus_req.addr == `OFF_LATCH_SET) begin
                wr_set = 1'b1;
            end else if (bus_req.addr == `OFF_LATCH_CLR) begin
                wr_clr = 1'b1;
            end else if (bus_req.addr == `OFF_IRQ_STATUS) begin
                wr_stat = 1'b1;
            end else if (bus_req.addr == `OFF_IRQ_MASK) begin
                wr_mask = 1'b1;
            end
        end
    end

    // control: half selects, ack combining and interrupt enable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl <= `RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl.dma_pins_select            <= bus_req.wdata[`CTRL_DMA_BIT];
            ctrl.serial_control_pins_select <= bus_req.wdata[`CTRL_SER_BIT];
            ctrl.combine_ack_pins           <= bus_req.wdata[`CTRL_CMB_BIT];
            ctrl.port_interrupt_enable      <= bus_req.wdata[`CTRL_IEN_BIT];
        end
    end

    // direction, one bit per line, all inputs after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_direction_register <= `RST_HALF;
        end else if (wr_dir) begin
            pin_direction_register <= bus_req.wdata[`GP_PINS-1:0];
        end
    end

    // readback seen by software and by the atomic set and clear writes
    assign readback = line_value(pin_direction_register,
                                 pin_output_latch_register,
                                 pin_level);

    // latch updates; set and clear modify the read value, so input lines pick up the pin
    always_comb begin
        next_latch = pin_output_latch_register;
        latch_wr   = 1'b0;
        if (wr_latch) begin
            next_latch = bus_req.wdata[`GP_PINS-1:0];
            latch_wr   = 1'b1;
        end else if (wr_set) begin
            next_latch = readback | bus_req.wdata[`GP_PINS-1:0];
            latch_wr   = 1'b1;
        end else if (wr_clr) begin
            next_latch = readback & ~bus_req.wdata[`GP_PINS-1:0];
            latch_wr   = 1'b1;
        end
    end

    // output latch register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_output_latch_register <= `RST_HALF;
        end else if (latch_wr) begin
            pin_output_latch_register <= next_latch;
        end
    end

    // lower half alternate data; combining frees the rx ack pins for plain use
    always_comb begin
        dma_data = dma_alt_out;
        dma_data[`ACK_TX_A] = dma_ack.tx_a;
        dma_data[`ACK_RX_A] = dma_ack.rx_a;
        dma_data[`ACK_TX_B] = dma_ack.tx_b;
        dma_data[`ACK_RX_B] = dma_ack.rx_b;
        if (ctrl.combine_ack_pins) begin
            dma_data[`ACK_TX_A] = dma_ack.tx_a | dma_ack.rx_a;
            dma_data[`ACK_TX_B] = dma_ack.tx_b | dma_ack.rx_b;
            dma_data[`ACK_RX_A] = 1'b1;
            dma_data[`ACK_RX_B] = 1'b1;
        end
    end

    // per-line alternate select; the combined rx pins fall back to the latch alone
    always_comb begin
        alt_sel = {{`GP_HALF{ctrl.serial_control_pins_select}},
                   {`GP_HALF{ctrl.dma_pins_select}}};
        if (ctrl.dma_pins_select && ctrl.combine_ack_pins) begin
            alt_sel[`ACK_RX_A] = 1'b0;
            alt_sel[`ACK_RX_B] = 1'b0;
        end
    end

    assign alt_data = {serial_alt_out, dma_data};

    // per-line pad logic
    genvar i;
    generate
        for (i = 0; i < `GP_PINS; i++) begin : g_line
            // push-pull when output, released when input; alternate gated by latch
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    gp_oe[i]  <= 1'b0;
                    gp_out[i] <= 1'b0;
                end else begin
                    gp_oe[i]  <= pin_direction_register[i];
                    if (alt_sel[i]) begin
                        gp_out[i] <= alt_data[i] & pin_output_latch_register[i];
                    end else begin
                        gp_out[i] <= pin_output_latch_register[i];
                    end
                end
            end
            // alternate input sees the latch when the line drives itself
            assign alt_in_all[i] = pin_direction_register[i] ?
                                   pin_output_latch_register[i] :
                                   pin_level[i];
        end
    endgenerate

    // alternate inputs reach their function only while the half is selected
    assign dma_alt_in    = ctrl.dma_pins_select ?
                           alt_in_all[`GP_HALF-1:0] : `VEC_ZERO_BYTE;
    assign serial_alt_in = ctrl.serial_control_pins_select ?
                           alt_in_all[`GP_PINS-1:`GP_HALF] : `VEC_ZERO_BYTE;
    assign dma_mode      = ctrl.dma_pins_select;
    assign serial_mode   = ctrl.serial_control_pins_select;

    // vector bytes; a half given to an alternate function reports zero
    assign upper_byte_vector = ctrl.serial_control_pins_select ?
                               `VEC_ZERO_BYTE : pin_level[`GP_PINS-1:`GP_HALF];
    assign lower_byte_vector = ctrl.dma_pins_select ?
                               `VEC_ZERO_BYTE : pin_level[`GP_HALF-1:0];

    // edge detector on the synchronised peripheral interrupt line
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            peri_irq_q <= 1'b0;
        end else begin
            peri_irq_q <= peri_irq_s;
        end
    end

    // rising edges while disabled are dropped, not queued
    assign vec_event = peri_irq_s & ~peri_irq_q & ctrl.port_interrupt_enable;

    // vector register, tag value is arbitrary
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_interrupt_vector <= `RST_WORD;
        end else if (vec_event) begin
            port_interrupt_vector <= {`VEC_TAG, upper_byte_vector,
                                      lower_byte_vector};
        end
    end

    // a new vector while the previous one is still flagged counts as overrun
    always_comb begin
        irq_events = `RST_IRQ;
        irq_events[`IRQ_VEC_BIT] = vec_event;
        irq_events[`IRQ_OVR_BIT] = vec_event & irq_status[`IRQ_VEC_BIT];
    end

    gp_irq_unit u_irq (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .event_set (irq_events),
        .clr_wr    (wr_stat),
        .clr_data  (bus_req.wdata[`GP_IRQ_W-1:0]),
        .mask_wr   (wr_mask),
        .mask_data (bus_req.wdata[`GP_IRQ_W-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq)
    );

    // read mux; unmapped addresses and write-only slots read zero
    always_comb begin
        next_rdata = `RST_WORD;
        if (bus_req.addr == `OFF_CTRL) begin
            next_rdata[`CTRL_W-1:0] = ctrl;
        end else if (bus_req.addr == `OFF_DIR) begin
            next_rdata[`GP_PINS-1:0] = pin_direction_register;
        end else if (bus_req.addr == `OFF_LATCH) begin
            next_rdata[`GP_PINS-1:0] = readback;
        end else if (bus_req.addr == `OFF_PIN) begin
            next_rdata[`GP_PINS-1:0] = pin_level;
        end else if (bus_req.addr == `OFF_VECTOR) begin
            next_rdata = port_interrupt_vector;
        end else if (bus_req.addr == `OFF_IRQ_STATUS) begin
            next_rdata[`GP_IRQ_W-1:0] = irq_status;
        end else if (bus_req.addr == `OFF_IRQ_MASK) begin
            next_rdata[`GP_IRQ_W-1:0] = irq_mask;
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata <= `RST_WORD;
        end else if (bus_req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `RST_WORD;
        end
    end

endmodule
`default_nettype wire

// ==== src/gp_port_cfg.svh ====
// Purpose: offsets, field positions, reset values and widths of the port block
// Assumes: 32-bit register port with byte addresses on an 8-bit address
// Notes:   definitions only
`ifndef GP_PORT_CFG_SVH
`define GP_PORT_CFG_SVH

`define GP_AW            8
`define GP_DW            32
`define GP_PINS          16
`define GP_HALF          8
`define GP_IRQ_W         2

// register byte offsets
`define OFF_CTRL         8'h00
`define OFF_DIR          8'h04
`define OFF_LATCH        8'h08
`define OFF_PIN          8'h0c
`define OFF_LATCH_SET    8'h10
`define OFF_LATCH_CLR    8'h14
`define OFF_VECTOR       8'h18
`define OFF_IRQ_STATUS   8'h1c
`define OFF_IRQ_MASK     8'h20

// control register fields
`define CTRL_DMA_BIT     0
`define CTRL_SER_BIT     1
`define CTRL_CMB_BIT     2
`define CTRL_IEN_BIT     3
`define CTRL_W           4

// interrupt status fields
`define IRQ_VEC_BIT      0
`define IRQ_OVR_BIT      1

// vector layout: tag in 31:16, upper byte 15:8, lower byte 7:0
`define VEC_TAG          16'h0a5c
`define VEC_ZERO_BYTE    8'h00

// lower half alternate pin positions used by ack combining
`define ACK_TX_A         0
`define ACK_RX_A         1
`define ACK_TX_B         2
`define ACK_RX_B         3

// reset values
`define RST_CTRL         4'h0
`define RST_HALF         16'h0000
`define RST_WORD         32'h0000_0000
`define RST_IRQ          2'h0

`endif

// ==== src/gp_port_pkg.sv ====
// Purpose: shared types of the port block
// Assumes: constants come from gp_port_cfg.svh
// Notes:   nothing here is imported; users write gp_port_pkg::name
package gp_port_pkg;

    // alternate function selection and interrupt enable
    typedef struct packed {
        logic port_interrupt_enable;
        logic combine_ack_pins;
        logic serial_control_pins_select;
        logic dma_pins_select;
    } ctrl_s;

    // dma acknowledge strobes from the local bus dma logic, active high
    typedef struct packed {
        logic rx_b;
        logic tx_b;
        logic rx_a;
        logic tx_a;
    } dma_ack_s;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

endpackage

// ==== src/gp_sync.sv ====
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to clk_sys
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module gp_sync #(
    parameter int WIDTH = 17
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage, read by the second stage only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= '0;
        end else begin
            meta <= async_in;
        end
    end

    // second stage is the input latch seen by the logic
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_out <= '0;
        end else begin
            sync_out <= meta;
        end
    end

endmodule
`default_nettype wire
